// ---- msd_top.sv ----
/*
  Stall detector: compares the per-step load value with twice a
  programmable threshold and pulses the fault event output.
  Assumes load_measurement_value and full_step are driven by the
  measurement engine on pclk; the measured_step_interval velocity input comes from
  the driver core on pclk. APB slave with zero wait states.
*/
`timescale 1ns/1ps
module msd_top import msd_pkg::*; (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Measurement engine
  input  wire logic [LOAD_W-1:0]  load_in,
  input  wire logic               full_step,
  input  wire logic [MEASURED_STEP_INTERVAL_W-1:0] measured_step_interval,
  // Outputs
  output logic             fault_event_output,
  output logic             stall_flag,
  output logic             irq
);
  logic [THR_W-1:0]   stall_threshold_reg;
  logic [MEASURED_STEP_INTERVAL_W-1:0] vthrs_reg;
  logic               quiet_reg;
  logic [LOAD_W-1:0]  load_measurement_value_reg;
  logic               upd_reg;
  logic               stall_reg;
  logic [IRQ_W-1:0]   irq_st_reg, irq_msk_reg;
  logic [31:0]        prdata_reg;

  // Bus decode
  wire acc    = psel & penable;
  wire wr     = acc & pwrite;
  wire rd     = acc & ~pwrite;
  wire hit_ct = (paddr == OFS_CTRL);
  wire hit_th = (paddr == OFS_THRS);
  wire hit_vt = (paddr == OFS_VTHRS);
  wire hit_ld = (paddr == OFS_LOAD);
  wire hit_ts = (paddr == OFS_MEASURED_STEP_INTERVAL);
  wire hit_st = (paddr == OFS_STATUS);
  wire hit_iq = (paddr == OFS_IRQST);
  wire hit_mk = (paddr == OFS_IRQMSK);
  wire mapped = hit_ct | hit_th | hit_vt | hit_ld | hit_ts | hit_st | hit_iq | hit_mk;

  // Doubled threshold; larger setting trips earlier, i.e. more sensitive [RL1] [RL5]
  wire [LOAD_W-1:0] thr_x2   = {1'b0, stall_threshold_reg, 1'b0};
  // Small value is heavy load, so below means stall [RL1] [RL6]
  wire              below    = (load_measurement_value_reg < thr_x2);
  // Velocity threshold acts as a lower speed limit [RL3] [RL11]
  wire              gate     = quiet_reg & (vthrs_reg >= measured_step_interval);
  // One request per fresh value only [RL2] [RL12]
  wire              trig     = upd_reg & below & gate;
  wire [IRQ_W-1:0]  irq_ev   = {upd_reg, trig};

  // Read mux
  wire [31:0] rd_val =
      hit_ct ? {31'h0, quiet_reg} :
      hit_th ? {24'h0, stall_threshold_reg} :
      hit_vt ? {12'h0, vthrs_reg} :
      hit_ld ? {22'h0, load_measurement_value_reg} :   // [RL10]
      hit_ts ? {12'h0, measured_step_interval} :
      hit_st ? {30'h0, gate, below} :
      hit_iq ? {30'h0, irq_st_reg} :
      hit_mk ? {30'h0, irq_msk_reg} : 32'h0;

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata  = prdata_reg;
  assign irq     = |(irq_st_reg & irq_msk_reg);

  // Configuration registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_threshold_reg <= THRS_RST;
      vthrs_reg           <= VTHRS_RST;
      quiet_reg           <= 1'b0;
      irq_msk_reg         <= '0;
    end else if (wr) begin
      if (hit_ct) quiet_reg           <= pwdata[CTRL_QUIET_BIT];
      if (hit_th) stall_threshold_reg <= pwdata[THR_W-1:0];
      if (hit_vt) vthrs_reg           <= pwdata[MEASURED_STEP_INTERVAL_W-1:0];
      if (hit_mk) irq_msk_reg         <= pwdata[IRQ_W-1:0];
    end
  end

  // Load value sampled only on a full step, held in between [RL4]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_measurement_value_reg <= LOAD_RST;
      upd_reg                    <= 1'b0;
    end else begin
      if (full_step) load_measurement_value_reg <= load_in;
      upd_reg <= full_step;
    end
  end

  // Stall flag follows the comparison of the held value [RL1]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stall_reg <= 1'b0;
    else          stall_reg <= below;
  end
  assign stall_flag = stall_reg;

  // Sticky events; a read clears only the bits it returned, so an event
  // landing between setup and access is kept, and a new event wins
  wire [IRQ_W-1:0] irq_clr = (rd & hit_iq) ? prdata_reg[IRQ_W-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_st_reg <= '0;
    else          irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_ev;
  end

  // Read data captured during the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)             prdata_reg <= 32'h0;
    else if (psel & ~penable) prdata_reg <= rd_val;
  end

  // Pulse shaping toward the motion controller [RL2] [RL12]
  msd_pulse u_pulse (
    .pclk    (pclk),
    .presetn (presetn),
    .trig    (trig),
    .pulse   (fault_event_output)
  );
endmodule // msd_top

// ---- msd_pkg.sv ----
/*
  Constants, register map and types for the motor stall detector.
  Assumes an APB master on pclk and a measurement engine that supplies
  a fresh load value together with a full-step strobe.
*/
// How it works
// RL1: stall flag when value below doubled threshold
// RL2: pulse fault output when value falls below
// RL3: pulses only in quiet chopper, threshold >= interval
// RL4: load value refreshed once per full step
// RL5: larger threshold means higher stall sensitivity
// RL6: smaller value means heavier load
// RL7: controller stops motor on single pulse
// RL8: controller starts tuning at half lowest value
// RL9: controller keeps current fixed after tuning
// RL10: load value is ten bit unsigned
// RL11: velocity threshold is lower limit versus interval
// RL12: at most one fixed-length pulse per update
package msd_pkg;
  // Widths
  localparam int LOAD_W   = 10;
  localparam int THR_W    = 8;
  localparam int MEASURED_STEP_INTERVAL_W  = 20;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_THRS   = 12'h004;
  localparam logic [11:0] OFS_VTHRS  = 12'h008;
  localparam logic [11:0] OFS_LOAD   = 12'h00c;
  localparam logic [11:0] OFS_MEASURED_STEP_INTERVAL  = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_IRQST  = 12'h018;
  localparam logic [11:0] OFS_IRQMSK = 12'h01c;
  // Field positions
  localparam int CTRL_QUIET_BIT = 0;
  localparam int ST_STALL_BIT   = 0;
  localparam int ST_GATE_BIT    = 1;
  localparam int IRQ_STALL_BIT  = 0;
  localparam int IRQ_UPD_BIT    = 1;
  localparam int IRQ_W          = 2;
  // Reset values
  localparam logic [THR_W-1:0]   THRS_RST  = 8'h00;
  localparam logic [MEASURED_STEP_INTERVAL_W-1:0] VTHRS_RST = 20'h00000;
  localparam logic [LOAD_W-1:0]  LOAD_RST  = 10'h3ff;
  // Pulse timing: printed time in ns, cycles derived from 50 ns clock
  localparam int PCLK_NS       = 50;
  localparam int PULSE_NS      = 200;
  localparam int PULSE_CYC_INT = (PULSE_NS + PCLK_NS - 1) / PCLK_NS;
  localparam logic [3:0] PULSE_CYC = 4'(PULSE_CYC_INT);
  // Pulse shaper states
  typedef enum logic [0:0] {
    MSD_IDLE  = 1'b0,
    MSD_PULSE = 1'b1
  } msd_state_t;
endpackage

// ---- msd_pulse.sv ----
/*
  Fixed-length pulse shaper for the fault event output.
  Assumes trig comes from logic on pclk, one cycle per request.
*/
`timescale 1ns/1ps
module msd_pulse import msd_pkg::*; (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Request and pulse
  input  wire logic trig,
  output logic      pulse
);
  msd_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  wire        last = (cnt_reg == 4'h1);

  // Counts the pulse out; a trigger during a pulse is dropped [RL12]
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      MSD_IDLE: begin
        if (trig) begin
          state_next = MSD_PULSE;
          cnt_next   = PULSE_CYC;
        end
      end
      MSD_PULSE: begin
        cnt_next = cnt_reg - 4'h1;
        if (last) state_next = MSD_IDLE;
      end
      default: state_next = MSD_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= MSD_IDLE;
      cnt_reg   <= 4'h0;
      pulse     <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      pulse     <= (state_next == MSD_PULSE);
    end
  end
endmodule // msd_pulse

// ---- msd_monitor.sv ----
/* Port checker for msd_top, bound below; assumes one pclk domain. */
`timescale 1ns/1ps
module msd_monitor import msd_pkg::*; (
  // APB
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Engine and outputs
  input wire logic [LOAD_W-1:0] load_in,
  input wire logic full_step, fault_event_output, stall_flag
);
  logic [LOAD_W-1:0] ld;
  logic [THR_W-1:0]  thr;
  logic              qt;
  wire               f  = fault_event_output;
  wire               rq = psel & penable;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadows of the stepped load and the written settings
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {ld, thr, qt} <= {LOAD_RST, THRS_RST, 1'h0};
    else begin
      if (full_step) ld <= load_in;
      if (rq && pwrite && paddr == OFS_THRS) thr <= pwdata[THR_W-1:0];
      if (rq && pwrite && paddr == OFS_CTRL) qt <= pwdata[CTRL_QUIET_BIT];
    end
  // Pulse start is allowed on edge 2 or 3 after the step, as the walk leaves it open
  a_pulse_len:
  assert property ($rose(f) |-> f[*4] ##1 !f) else $error("pulse length");
  a_pulse_cause:
  assert property ($rose(f) |-> $past(full_step, 2) || $past(full_step, 3)) else $error("pulse cause");
  a_pulse_stall:
  assert property ($rose(f) |-> stall_flag) else $error("pulse without stall");
  a_quiet_gate:
  assert property ($rose(f) |-> qt) else $error("pulse while not quiet");
  a_stall_cmp:
  assert property ($past(full_step, 4) |-> stall_flag == (ld < {thr, 1'h0})) else $error("stall compare");
  a_load_read:
  assert property (rq && !pwrite && paddr == OFS_LOAD |-> prdata == 32'(ld)) else $error("load read");
  a_ready_high:
  assert property (rq |-> pready) else $error("wait state");
  a_unmapped_err:
  assert property (rq && paddr > OFS_IRQMSK |-> pslverr && prdata == 32'h0) else $error("unmapped");
  c_pulse: cover property ($rose(f));
  c_stall: cover property (stall_flag && !f);
  c_unmapped: cover property (pslverr);
endmodule // msd_monitor
bind msd_top msd_monitor u_mon (.*);

// ---- msd_ctl_model.sv ----
/* Motion controller model on the fault line; assumes pulses on pclk. */
`timescale 1ns/1ps
module msd_ctl_model (
  // Clock, reset and fault line
  input wire logic pclk, presetn, fault_event_output,
  // Stop request and pulse count
  output logic     stop_req,
  output int       n_pulses
);
  logic prev;
  // One rising edge means stall; no filtering, so repeats also count
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {prev, stop_req, n_pulses} <= '0;
    else begin
      prev <= fault_event_output;
      if (fault_event_output && !prev) stop_req <= 1'h1;
      if (fault_event_output && !prev) n_pulses <= n_pulses + 1;
    end
endmodule // msd_ctl_model

// ---- msd_top_tb.sv ----
/* Bench for msd_top: APB tasks and a table of load steps; needs the model and checker. */
`timescale 1ns/1ps
module msd_top_tb import msd_pkg::*;;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, full_step = 1'h0;
  logic pready, pslverr, fault_event_output, stall_flag, irq, stop_req, err, q, st, pl;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [9:0]  load_in = 10'h0;
  logic [19:0] measured_step_interval = 20'h0, ms;
  int          err_count = 0, n_compared = 0, n_pulses, base;
  // Rows: threshold and stepped load; row 3 leaves quiet mode, row 4 is too slow
  logic [7:0]  thr_t [5] = '{8'h40, 8'h40, 8'h50, 8'h40, 8'h40};
  logic [9:0]  ld_t [5]  = '{10'h07f, 10'h080, 10'h090, 10'h010, 10'h010};
  msd_top DUT (.*);
  msd_ctl_model u_ctl (.*);
  initial forever #25 pclk = ~pclk;
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    n_compared++;
    if (s !== e) err_count++;
    if (s !== e) $display("unexpected %s: expected %h, seen %h", n, e, s);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100us;
    err_count++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, OFS_LOAD, 32'h0);
    chk("load reset", 32'(LOAD_RST), rd);
    apb(1'h0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    apb(1'h1, OFS_VTHRS, 32'h3e8);
    for (int i = 0; i < 5; i++) begin
      q = (i != 3);
      ms = (i == 4) ? 20'h3e9 : 20'h3e8;
      // Motor current is never touched once the threshold is set
      apb(1'h1, OFS_THRS, 32'(thr_t[i]));
      apb(1'h1, OFS_CTRL, 32'(q));
      apb(1'h1, OFS_IRQMSK, (i != 0) ? 32'h3 : 32'h0);
      {base, measured_step_interval, full_step, load_in} <= {n_pulses, ms, 1'h1, ld_t[i]};
      @(posedge pclk);
      {full_step, load_in} <= {1'h0, ~ld_t[i]};
      repeat (8) @(posedge pclk);
      #1;
      st = ld_t[i] < {thr_t[i], 1'h0};
      pl = st & q & (ms <= 20'h3e8);
      chk("stall flag", 32'(st), 32'(stall_flag));
      chk("pulses", 32'(pl), n_pulses - base);
      chk("irq", 32'(i != 0), 32'(irq));
      apb(1'h0, OFS_LOAD, 32'h0);
      chk("load held", 32'(ld_t[i]), rd);
      apb(1'h0, OFS_IRQST, 32'h0);
      #1;
      chk("irq status", 32'({1'h1, pl}), rd);
      chk("irq clear", 32'h0, 32'(irq));
    end
    chk("stop", 32'h1, 32'(stop_req));
    tally_and_finish;
  end
endmodule // msd_top_tb
